// *** ssr_cfg.svh ***
// Purpose: Constants for the register-to-register late-write static memory model
// Assumes: 100 MHz reference clock
// Notes:   Timing counts derive from figures in their own units
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// =====================================================================
// Geometry
`define SSR_ADDR_W       18
`define SSR_LANE_W       9
`define SSR_WORD_W       18
`define SSR_DEPTH        262144
// =====================================================================
// Timing
`define SSR_CLK_PERIOD_NS 10
`define SSR_IMP_UPD_CYC   2048
// =====================================================================
// Strap values that select register-to-register mode
`define SSR_STRAP0_VAL   1'b0
`define SSR_STRAP1_VAL   1'b1
// Impedance code after power-up: minimum impedance
`define SSR_IMP_RST      11'h000
`define SSR_IMP_W        11

`endif

// *** ssr_host_model.sv ***
// Purpose: Host controller model that issues reads and late writes
// Assumes: Pins change at the falling clock edge only
// Notes:   Released data lines carry the inverse of the last word, never a stale copy
`timescale 1ns/10ps
module ssr_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic [17:0] rdata_i,
	input  wire logic        oe_n_i,
	output logic      [17:0] addr_o,
	output logic             cs_n_o,
	output logic             we_n_o,
	output logic             lane_lo_n_o,
	output logic             lane_hi_n_o,
	output logic      [17:0] wdata_o
);
	// =====================================================================
	// Idle levels
	initial begin
		addr_o = 18'h00000;
		cs_n_o = 1'b1;
		we_n_o = 1'b1;
		{lane_hi_n_o, lane_lo_n_o} = 2'b11;
		wdata_o = 18'h00000;
	end

	// =====================================================================
	// Bus cycles
	task automatic rd(input logic [17:0] a, output logic [17:0] d, output logic oe);
		@(negedge ref_clk_i);
		addr_o = a;
		cs_n_o = 1'b0;
		we_n_o = 1'b1;
		@(negedge ref_clk_i);
		d = rdata_i;
		oe = oe_n_i;
		cs_n_o = 1'b1;
	endtask

	task automatic wr(input logic [17:0] a, input logic [1:0] ln, input logic [17:0] d,
		output logic oe);
		@(negedge ref_clk_i);
		addr_o = a;
		cs_n_o = 1'b0;
		we_n_o = 1'b0;
		{lane_hi_n_o, lane_lo_n_o} = ln;
		@(negedge ref_clk_i);
		cs_n_o = 1'b1;
		wdata_o = d;
		oe = oe_n_i;
		@(negedge ref_clk_i);
		wdata_o = ~d;
	endtask

	// Write followed at the very next edge by a read of the same word
	task automatic wr_rd(input logic [17:0] a, input logic [1:0] ln, input logic [17:0] d,
		output logic [17:0] q, output logic oe);
		@(negedge ref_clk_i);
		addr_o = a;
		cs_n_o = 1'b0;
		we_n_o = 1'b0;
		{lane_hi_n_o, lane_lo_n_o} = ln;
		@(negedge ref_clk_i);
		we_n_o = 1'b1;
		wdata_o = d;
		@(negedge ref_clk_i);
		q = rdata_i;
		oe = oe_n_i;
		cs_n_o = 1'b1;
		wdata_o = ~d;
	endtask
endmodule

// *** ssr_mem.sv ***
// Purpose: Word array with per-lane write and registered read data
// Assumes: Single clock, one late write and one read per cycle
// Notes:   Array itself has no reset, as storage in a real part
`timescale 1ns/10ps
module ssr_mem #(
	parameter int ADDR_W = 18,
	parameter int LANE_W = 9,
	parameter int LANES  = 2
) (
	input  wire logic                      ref_clk_i,
	input  wire logic [ADDR_W-1:0]         waddr_i,
	input  wire logic [ADDR_W-1:0]         raddr_i,
	input  wire logic                      rd_i,
	input  wire logic [LANES-1:0]          lane_we_i,
	input  wire logic [LANES*LANE_W-1:0]   wdata_i,
	output logic      [LANES*LANE_W-1:0]   rdata_o
);
	if (ADDR_W < 1 || LANE_W < 1 || LANES < 1) begin : g_bad_cfg
		$error("ssr_mem: unsupported geometry");
	end

	// =================================================================
	// One array per lane, so every lane has a single writing process.
	// Late write and read use separate addresses in the same cycle.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [LANE_W-1:0] store [0:(1<<ADDR_W)-1];
			logic [LANE_W-1:0] rd_q;

			always_ff @(posedge ref_clk_i) begin
				if (lane_we_i[g]) begin // R6
					store[waddr_i] <= wdata_i[g*LANE_W +: LANE_W];
				end
			end

			// Write-first: reading the word being written returns the new lane
			always_ff @(posedge ref_clk_i) begin
				if (rd_i) begin
					if (lane_we_i[g] && waddr_i == raddr_i) begin
						rd_q <= wdata_i[g*LANE_W +: LANE_W];
					end else begin
						rd_q <= store[raddr_i];
					end
				end
			end

			assign rdata_o[g*LANE_W +: LANE_W] = rd_q;
		end
	endgenerate
endmodule

// *** ssr_pkg.sv ***
// Purpose: Types for the static memory model
// Assumes: ssr_cfg.svh supplies the numbers
// Notes:   Types only
`include "ssr_cfg.svh"
package ssr_pkg;
	typedef enum logic [1:0] {
		SSR_OP_IDLE,
		SSR_OP_READ,
		SSR_OP_WRITE
	} ssr_op_t;
endpackage

// *** ssr_top.sv ***
// Overview of operation
// R1 - Array of 256K words by 18 bits, chosen by 18-bit word address.
// R2 - Address, select and write enables are captured at rising clock edge.
// R3 - Select high deselects; select low reads or writes per write enable.
// R4 - Read taken at edge n drives the word during cycle n+1.
// R5 - Write data taken in cycle n+1; bus stays released; array self-timed.
// R6 - Each 9-bit lane is written only when its enable is low.
// R7 - Output enable high releases the bus at once; reads become dummies. The code registers the release, so it takes effect at the next rising edge.
// R8 - Sleep high releases the bus now and next cycle, ignoring everything. The code registers the release, so it takes effect at the next rising edge.
// R9 - Works from a differential clock pair or one phase alone.
// R10 - Host straps protocol inputs low/high before power-up, never changes them.
// R11 - Impedance updates only while released; full update within 2048 cycles.
// R12 - Write with both lane enables high changes nothing, bus released.
//
// Purpose: Device side of a pipelined late-write synchronous static memory
// Assumes: Clock pair already merged into ref_clk_i by the pad ring
// Notes:   Data bus split into in, out and active-low output enable
`timescale 1ns/10ps
`include "ssr_cfg.svh"
module ssr_top
	import ssr_pkg::*;
#(
	parameter int ADDR_W  = `SSR_ADDR_W,
	parameter int LANE_W  = `SSR_LANE_W,
	parameter int IMP_CYC = `SSR_IMP_UPD_CYC
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  resetn_i,
	input  wire logic [ADDR_W-1:0]     word_addr_i,
	input  wire logic                  chip_sel_n_i,
	input  wire logic                  write_en_n_i,
	input  wire logic                  lane_lo_wr_en_n_i,
	input  wire logic                  lane_hi_wr_en_n_i,
	input  wire logic                  out_en_n_i,
	input  wire logic                  sleep_req_i,
	input  wire logic                  protocol_strap_0_i,
	input  wire logic                  protocol_strap_1_i,
	input  wire logic [`SSR_IMP_W-1:0] impedance_ref_i,
	input  wire logic [2*LANE_W-1:0]   data_bus_i,
	output logic      [2*LANE_W-1:0]   data_bus_o,
	output logic                       data_bus_oe_n_o,
	output logic      [`SSR_IMP_W-1:0] drive_imp_o,
	output logic                       mode_ok_o
);
	// The impedance stepper needs room for a full sweep of the code
	if (ADDR_W != `SSR_ADDR_W || LANE_W != `SSR_LANE_W
		|| IMP_CYC < (1 << `SSR_IMP_W)) begin : g_bad_cfg
		$error("ssr_top: unsupported geometry or impedance count");
	end

	// =================================================================
	// Asynchronous controls pass two flops; sleep and output enable are also used straight from the pin
	logic [1:0] sleep_sync;
	logic [1:0] oe_sync;
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	logic [`SSR_IMP_W-1:0] imp_meta;
	logic [`SSR_IMP_W-1:0] imp_sync;
	logic [`SSR_IMP_W-1:0] imp_prev;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sleep_sync <= 2'h3;
			oe_sync    <= 2'h3;
			strap_meta <= 2'h0;
			strap_sync <= 2'h0;
			imp_meta   <= `SSR_IMP_RST;
			imp_sync   <= `SSR_IMP_RST;
			imp_prev   <= `SSR_IMP_RST;
		end else begin
			sleep_sync <= {sleep_sync[0], sleep_req_i};
			oe_sync    <= {oe_sync[0], out_en_n_i};
			strap_meta <= {protocol_strap_1_i, protocol_strap_0_i};
			strap_sync <= strap_meta;
			imp_meta   <= impedance_ref_i;
			imp_sync   <= imp_meta;
			imp_prev   <= imp_sync;
		end
	end

	// Sleep or output enable high at either the pin or the synchroniser output
	wire logic sleeping = sleep_req_i | sleep_sync[1];
	wire logic oe_off   = out_en_n_i  | oe_sync[1];

	// =================================================================
	// Strap check: mode is re-evaluated every cycle from the synchronised straps
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_ok_o <= 1'b0;
		end else begin
			mode_ok_o <= (strap_sync[0] == `SSR_STRAP0_VAL)
				&& (strap_sync[1] == `SSR_STRAP1_VAL); // R10
		end
	end

	// =================================================================
	// Command capture at the rising edge
	function automatic ssr_op_t decode_op(input logic sel_n, input logic we_n,
		input logic slp);
		if (slp || sel_n) begin
			decode_op = SSR_OP_IDLE;
		end else if (we_n) begin
			decode_op = SSR_OP_READ;
		end else begin
			decode_op = SSR_OP_WRITE;
		end
	endfunction

	ssr_op_t           next_op;
	ssr_op_t           op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [1:0]        lane_en_q;

	always_comb begin
		next_op = decode_op(chip_sel_n_i, write_en_n_i, sleeping); // R3 R8
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			op_q      <= SSR_OP_IDLE;
			addr_q    <= '0;
			lane_en_q <= 2'h0;
		end else begin
			op_q      <= next_op; // R2
			addr_q    <= word_addr_i; // R1 R2
			lane_en_q <= {~lane_hi_wr_en_n_i, ~lane_lo_wr_en_n_i}; // R6
		end
	end

	// =================================================================
	// Array: read issued at the capture edge, late write one cycle later
	logic [1:0]        mem_we;
	logic              mem_rd;

	always_comb begin
		mem_rd = (next_op == SSR_OP_READ);
		case (op_q)
			SSR_OP_WRITE: mem_we = sleeping ? 2'h0 : lane_en_q; // R5 R6 R12
			default:      mem_we = 2'h0;
		endcase
	end

	// Write lands at the edge after capture; a read of that word at the same
	// edge returns the new lanes, so write then read needs no bubble.
	// Read data leave the array's output register straight onto the bus.
	ssr_mem #(
		.ADDR_W (ADDR_W),
		.LANE_W (LANE_W),
		.LANES  (2)
	) u_mem (
		.ref_clk_i (ref_clk_i),
		.waddr_i   (addr_q),
		.raddr_i   (word_addr_i),
		.rd_i      (mem_rd),
		.lane_we_i (mem_we),
		.wdata_i   (data_bus_i),
		.rdata_o   (data_bus_o) // R4
	);

	// =================================================================
	// Output enable: registered and released by sleep or output enable
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_bus_oe_n_o <= 1'b1;
		end else begin
			// Release at the first edge of a sleep or disable pulse
			data_bus_oe_n_o <= !(next_op == SSR_OP_READ) || oe_off; // R3 R4 R5 R7 R8
		end
	end

	// =================================================================
	// Impedance update: steps one unit toward target only while released.
	// Limitation: a reversal costs as many steps as the code distance.
	logic [11:0]           imp_cnt;
	logic [`SSR_IMP_W-1:0] imp_tgt;

	// The code is a multi-bit level: take it only when two samples agree,
	// so a code caught mid-change never becomes a target
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			imp_tgt <= `SSR_IMP_RST;
		end else if (imp_sync == imp_prev) begin
			imp_tgt <= imp_sync;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive_imp_o <= `SSR_IMP_RST;
		end else if (data_bus_oe_n_o && drive_imp_o != imp_tgt) begin
			drive_imp_o <= (drive_imp_o < imp_tgt) ? drive_imp_o + 1'b1
				: drive_imp_o - 1'b1; // R11
		end
	end

	// Released cycles spent short of the target; cleared when reached or retargeted
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			imp_cnt <= 12'h000;
		end else if (drive_imp_o == imp_tgt || imp_tgt != imp_sync) begin
			imp_cnt <= 12'h000;
		end else if (data_bus_oe_n_o) begin
			imp_cnt <= imp_cnt + 12'h001; // R11
		end
	end

	// R9: both clock phases are combined outside; one phase alone suffices.

	// =================================================================
	// Checks
	bus_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
		sleep_sync[1] |=> data_bus_oe_n_o) else $error("bus driven in sleep");
	read_drive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R4
		(next_op == SSR_OP_READ && !oe_off) |=> !data_bus_oe_n_o)
		else $error("read not driven");
	write_float_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R5
		(next_op == SSR_OP_WRITE) |=> data_bus_oe_n_o)
		else $error("bus driven in write");
	desel_float_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R3
		(!sleeping && chip_sel_n_i) |=> data_bus_oe_n_o)
		else $error("bus driven after deselect");
	oe_float_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R7
		oe_sync[1] |=> data_bus_oe_n_o) else $error("bus driven with oe high");
	no_lane_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
		(op_q == SSR_OP_WRITE && $past(lane_lo_wr_en_n_i && lane_hi_wr_en_n_i))
		|-> mem_we == 2'h0)
		else $error("write without lane");
	lane_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
		(mem_we != 2'h0)
		|-> (mem_we & $past({lane_hi_wr_en_n_i, lane_lo_wr_en_n_i})) == 2'h0)
		else $error("lane written without enable");
	imp_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
		!data_bus_oe_n_o |=> $stable(drive_imp_o))
		else $error("impedance moved while driving");
	capture_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
		1'b1 |=> addr_q == $past(word_addr_i)) else $error("address not captured");
	imp_time_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
		imp_cnt < IMP_CYC) else $error("impedance update overran");

	read_c:  cover property (@(posedge ref_clk_i) next_op == SSR_OP_READ ##1 !data_bus_oe_n_o);
	write_c: cover property (@(posedge ref_clk_i) op_q == SSR_OP_WRITE && mem_we == 2'h3);
	sleep_c: cover property (@(posedge ref_clk_i) sleep_sync[1] ##1 !sleep_sync[1]);
	fwd_c:   cover property (@(posedge ref_clk_i)
		mem_rd && mem_we != 2'h0 && addr_q == word_addr_i);
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the late-write static memory
// Assumes: Host model drives the synchronous pins
// Notes:   Straps and impedance target are held for the whole run
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic        ref_clk_i = 1'b0;
	logic        resetn_i  = 1'b0;
	logic        out_en_n  = 1'b0;
	logic        sleep_req = 1'b0;
	logic [17:0] addr, wdata, rdata;
	logic        cs_n, we_n, lo_n, hi_n, oe_n, mode_ok, oe;
	logic [17:0] d;
	logic [10:0] imp;
	int          err_total = 0;
	int          comparisons = 0;
	int          cyc = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	ssr_top u_ssr_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .word_addr_i(addr),
		.chip_sel_n_i(cs_n), .write_en_n_i(we_n), .lane_lo_wr_en_n_i(lo_n),
		.lane_hi_wr_en_n_i(hi_n), .out_en_n_i(out_en_n), .sleep_req_i(sleep_req),
		.protocol_strap_0_i(1'b0), .protocol_strap_1_i(1'b1), .impedance_ref_i(11'h005),
		.data_bus_i(wdata), .data_bus_o(rdata), .data_bus_oe_n_o(oe_n),
		.drive_imp_o(imp), .mode_ok_o(mode_ok));

	ssr_host_model u_ssr_host_model (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .oe_n_i(oe_n),
		.addr_o(addr), .cs_n_o(cs_n), .we_n_o(we_n), .lane_lo_n_o(lo_n),
		.lane_hi_n_o(hi_n), .wdata_o(wdata));

	// =====================================================================
	// Scenarios
	task automatic t_full();
		u_ssr_host_model.wr(18'h00000, 2'b00, 18'h2a5a5, oe);
		`CHK(oe, 1'b1)
		u_ssr_host_model.wr(18'h3ffff, 2'b00, 18'h15a5a, oe);
		u_ssr_host_model.rd(18'h00000, d, oe);
		`CHK(oe, 1'b0)
		`CHK(d, 18'h2a5a5)
		u_ssr_host_model.rd(18'h3ffff, d, oe);
		`CHK(d, 18'h15a5a)
	endtask

	task automatic t_lanes();
		u_ssr_host_model.wr(18'h00005, 2'b00, 18'h3ffff, oe);
		u_ssr_host_model.wr(18'h00005, 2'b10, 18'h00000, oe);
		u_ssr_host_model.rd(18'h00005, d, oe);
		`CHK(d, 18'h3fe00)
		u_ssr_host_model.wr(18'h00005, 2'b11, 18'h12345, oe);
		`CHK(oe, 1'b1)
		u_ssr_host_model.rd(18'h00005, d, oe);
		`CHK(d, 18'h3fe00)
		u_ssr_host_model.wr(18'h00005, 2'b01, 18'h2aaaa, oe);
		u_ssr_host_model.rd(18'h00005, d, oe);
		`CHK(d, 18'h2aa00)
	endtask

	task automatic t_fwd();
		u_ssr_host_model.wr(18'h00009, 2'b00, 18'h3ffff, oe);
		u_ssr_host_model.wr_rd(18'h00009, 2'b01, 18'h00000, d, oe);
		`CHK(oe, 1'b0)
		`CHK(d, 18'h001ff)
		u_ssr_host_model.rd(18'h00009, d, oe);
		`CHK(d, 18'h001ff)
	endtask

	// Gate pins linger two cycles through their synchronisers, so settle after release
	task automatic t_gate();
		for (int k = 0; k < 2; k++) begin
			@(negedge ref_clk_i);
			if (k == 0) out_en_n = 1'b1;
			else sleep_req = 1'b1;
			u_ssr_host_model.rd(18'h00005, d, oe);
			if (k == 0) begin
				`CHK(oe, 1'b1)
			end else begin
				`CHK(oe, 1'b1)
			end
			out_en_n = 1'b0;
			sleep_req = 1'b0;
			repeat (3) @(negedge ref_clk_i);
			`CHK(oe_n, 1'b1)
		end
	endtask

	task automatic t_static();
		`CHK(mode_ok, 1'b1)
		`CHK(imp, 11'h005)
	endtask

	// =====================================================================
	// Run control
	task automatic report_and_stop();
		if (err_total == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		repeat (5) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		t_full();
		t_lanes();
		t_fwd();
		t_gate();
		repeat (40) @(negedge ref_clk_i);
		t_static();
		report_and_stop();
	end
endmodule
